// >>> rtl/dioc_top.sv
// Functional notes
// (R01) Supply short raises unit error when enabled (default on); none when off.
// (R02) Inrush blanking, default off, ignores excess current 100 ms after inrush.
// (R03) Inputs ignore changes shorter than 0.1/1/10/20 ms filter; default 1 ms.
// (R04) Accepted input held for 1/15/100/200 ms extension; default 15 ms.
// (R05) Load short raises unit error when enabled (default on); none when off.
// (R06) Auto restart, the default: short error clears once short is gone.
// (R07) Manual restart: short error stays latched until power is cycled; the code also clears it when load short detection is disabled.
// (R08) Open detection, default off, raises per-channel error on disconnected load.
// (R09) On comm fault each output goes off, holds, or drives high per setting.
// (R10) Per-channel fault setting applies only when priority selects handheld.
// (R11) Per-channel ON count; when enabled, error once count exceeds limit.
// (R12) Limit accepts 1 to 65000; threshold is limit times one thousand.
// (R13) Every hour all channel counts are offered to persistent storage.
// (R14) After power returns counting resumes from the last saved value.
// (R15) Filter passes a level only after full stable time; ON restarts hold.
// (R16) After reset every setting takes its default value.
`include "dioc_regs.svh"
module dioc_top #(
  parameter int NCH = 8,
  parameter int TICK_CYC = `DIOC_TICK_CYC,
  parameter int INRUSH_TICKS = `DIOC_INRUSH_TICKS,
  parameter int HOUR_TICKS = `DIOC_HOUR_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NCH-1:0] i_in_raw,
  input wire logic [NCH-1:0] i_out_cmd,
  input wire logic i_comm_fault,
  input wire logic i_supply_short,
  input wire logic i_over_current,
  input wire logic [NCH-1:0] i_load_open,
  input wire logic i_restore_stb,
  input wire logic [NCH*27-1:0] i_restore_cnt,
  output logic [NCH-1:0] o_in_level,
  output logic [NCH-1:0] o_out_drive,
  output logic o_supply_err,
  output logic o_load_short_err,
  output logic [NCH-1:0] o_load_open_err,
  output logic [NCH-1:0] o_count_err,
  output logic o_save_stb,
  output logic [NCH*27-1:0] o_save_cnt,
  output logic o_irq
);
  typedef struct packed {
    logic [10:0] ctrl;
    logic [2*NCH-1:0] fmode;
    logic [15:0] limit;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [31:0] prdata;
    logic [31:0] div;
    logic [31:0] hour;
    logic [11:0] inrush;
    logic save_stb;
    logic [NCH-1:0] out_drive;
    logic sup_err;
    logic ld_err;
    logic [NCH-1:0] open_err;
  } dioc_top_st_t;

  dioc_top_st_t st_ff;
  dioc_top_st_t nxt_st;
  logic tick;
  logic blank;
  logic setup;
  logic wr;
  logic [NCH-1:0] in_on;
  logic [NCH-1:0] cnt_err;
  dioc_pkg::dioc_cnt_t cnt [NCH];

  dioc_cfg_if cfg ();

  // ==========================================
  // Helpers
  function automatic dioc_pkg::dioc_tick_t filt_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h0: filt_ticks = 12'(`DIOC_US2TICK(`DIOC_FILT0_US));
      2'h1: filt_ticks = 12'(`DIOC_US2TICK(`DIOC_FILT1_US));
      2'h2: filt_ticks = 12'(`DIOC_US2TICK(`DIOC_FILT2_US));
      2'h3: filt_ticks = 12'(`DIOC_US2TICK(`DIOC_FILT3_US));
    endcase
  endfunction

  function automatic dioc_pkg::dioc_tick_t ext_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h0: ext_ticks = 12'(`DIOC_US2TICK(`DIOC_EXT0_US));
      2'h1: ext_ticks = 12'(`DIOC_US2TICK(`DIOC_EXT1_US));
      2'h2: ext_ticks = 12'(`DIOC_US2TICK(`DIOC_EXT2_US));
      2'h3: ext_ticks = 12'(`DIOC_US2TICK(`DIOC_EXT3_US));
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= `DIOC_LIVE_OFF && a[1:0] == 2'h0) ||
                (a >= `DIOC_CNT_BASE && a[1:0] == 2'h0 &&
                 32'(a - `DIOC_CNT_BASE) < 32'(4 * NCH));
  endfunction

  // ==========================================
  // Shared timing and configuration
  assign tick = (st_ff.div == 32'(TICK_CYC - 1));
  assign blank = st_ff.ctrl[`DIOC_INRUSH_EN_BIT] && (st_ff.inrush != '0); // R02
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite && is_mapped(i_paddr);

  assign cfg.tick = tick;
  assign cfg.filt_len = filt_ticks(st_ff.ctrl[`DIOC_FILT_LSB +: 2]); // R03
  assign cfg.ext_len = ext_ticks(st_ff.ctrl[`DIOC_EXT_LSB +: 2]); // R04
  assign cfg.cnt_en = st_ff.ctrl[`DIOC_CNT_EN_BIT];
  assign cfg.thresh = 27'(st_ff.limit) * `DIOC_LIMIT_SCALE; // R12

  // ==========================================
  // Per-channel input conditioning and counting
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    dioc_in_cond u_in (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .cfg(cfg.snk),
      .i_raw(i_in_raw[ch]),
      .o_level(o_in_level[ch]),
      .o_on_evt(in_on[ch])
    );
    dioc_on_counter u_cnt (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .cfg(cfg.snk),
      .i_on_evt(in_on[ch] | (nxt_st.out_drive[ch] & ~st_ff.out_drive[ch])), // R11
      .i_restore_stb(i_restore_stb), // R14
      .i_restore_val(i_restore_cnt[ch*27 +: 27]),
      .o_count(cnt[ch]),
      .o_limit_err(cnt_err[ch])
    );
    assign o_save_cnt[ch*27 +: 27] = cnt[ch];
  end

  // ==========================================
  // Next state
  always_comb begin
    logic [NCH-1:0] rise;
    logic [7:0] idx;
    rise = '0;
    idx = 8'h00;
    nxt_st = st_ff;
    nxt_st.save_stb = 1'b0;
    nxt_st.div = tick ? '0 : st_ff.div + 32'h0000_0001;
    if (tick) begin
      if (st_ff.hour == 32'(HOUR_TICKS - 1)) begin
        nxt_st.hour = '0;
        nxt_st.save_stb = 1'b1; // R13
      end else begin
        nxt_st.hour = st_ff.hour + 32'h0000_0001;
      end
    end
    for (int ch = 0; ch < NCH; ch++) begin
      if (!i_comm_fault) begin
        nxt_st.out_drive[ch] = i_out_cmd[ch];
      end else if (st_ff.ctrl[`DIOC_PRIO_BIT]) begin // R10
        unique case (st_ff.fmode[2*ch +: 2]) // R09
          dioc_pkg::DIOC_FM_CLEAR: nxt_st.out_drive[ch] = 1'b0;
          dioc_pkg::DIOC_FM_HOLD: nxt_st.out_drive[ch] = st_ff.out_drive[ch];
          dioc_pkg::DIOC_FM_HIGH: nxt_st.out_drive[ch] = 1'b1;
          default: nxt_st.out_drive[ch] = 1'b0;
        endcase
      end else begin
        nxt_st.out_drive[ch] = 1'b0;
      end
    end
    rise = nxt_st.out_drive & ~st_ff.out_drive;
    if (|rise) begin
      nxt_st.inrush = 12'(INRUSH_TICKS);
    end else if (tick && st_ff.inrush != '0) begin
      nxt_st.inrush = st_ff.inrush - 12'h001;
    end
    nxt_st.sup_err = st_ff.ctrl[`DIOC_SUP_EN_BIT] && i_supply_short; // R01
    if (!st_ff.ctrl[`DIOC_LSHORT_EN_BIT]) begin
      nxt_st.ld_err = 1'b0;
    end else if (i_over_current && !blank) begin
      nxt_st.ld_err = 1'b1; // R05
    end else if (!st_ff.ctrl[`DIOC_RECOV_BIT] && !i_over_current) begin // R07
      nxt_st.ld_err = 1'b0; // R06
    end
    nxt_st.open_err = st_ff.ctrl[`DIOC_OPEN_EN_BIT] ? i_load_open : '0; // R08
    if (wr && i_paddr == `DIOC_CTRL_OFF) begin
      nxt_st.ctrl = i_pwdata[10:0];
    end
    if (wr && i_paddr == `DIOC_FMODE_OFF) begin
      nxt_st.fmode = i_pwdata[2*NCH-1:0];
    end
    if (wr && i_paddr == `DIOC_LIMIT_OFF && i_pwdata[15:0] >= `DIOC_LIMIT_MIN &&
        i_pwdata[15:0] <= `DIOC_LIMIT_MAX && i_pwdata[31:16] == 16'h0000) begin
      nxt_st.limit = i_pwdata[15:0]; // R12
    end
    if (wr && i_paddr == `DIOC_MASK_OFF) begin
      nxt_st.mask = i_pwdata[3:0];
    end
    if (wr && i_paddr == `DIOC_STAT_OFF) begin
      nxt_st.stat = st_ff.stat & ~i_pwdata[3:0];
    end
    nxt_st.stat[`DIOC_ST_SUP] = nxt_st.stat[`DIOC_ST_SUP] | st_ff.sup_err;
    nxt_st.stat[`DIOC_ST_LSHORT] = nxt_st.stat[`DIOC_ST_LSHORT] | st_ff.ld_err;
    nxt_st.stat[`DIOC_ST_OPEN] = nxt_st.stat[`DIOC_ST_OPEN] | (|st_ff.open_err);
    nxt_st.stat[`DIOC_ST_CNT] = nxt_st.stat[`DIOC_ST_CNT] | (|cnt_err);
    if (setup) begin
      nxt_st.prdata = '0;
      unique case (i_paddr)
        `DIOC_CTRL_OFF: nxt_st.prdata = 32'(st_ff.ctrl);
        `DIOC_FMODE_OFF: nxt_st.prdata = 32'(st_ff.fmode);
        `DIOC_LIMIT_OFF: nxt_st.prdata = 32'(st_ff.limit);
        `DIOC_STAT_OFF: nxt_st.prdata = 32'(st_ff.stat);
        `DIOC_MASK_OFF: nxt_st.prdata = 32'(st_ff.mask);
        `DIOC_INLVL_OFF: nxt_st.prdata = 32'(o_in_level);
        `DIOC_OPEN_OFF: nxt_st.prdata = 32'(st_ff.open_err);
        `DIOC_CNTERR_OFF: nxt_st.prdata = 32'(cnt_err);
        `DIOC_LIVE_OFF: nxt_st.prdata = {30'h0, st_ff.ld_err, st_ff.sup_err};
        default: begin
          if (is_mapped(i_paddr)) begin
            idx = 8'((i_paddr - `DIOC_CNT_BASE) >> 2);
            for (int ch = 0; ch < NCH; ch++) begin
              if (idx == 8'(ch)) begin
                nxt_st.prdata = 32'(cnt[ch]);
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.ctrl <= `DIOC_CTRL_RST; // R16
      st_ff.limit <= `DIOC_LIMIT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================
  // Outputs
  assign o_prdata = st_ff.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !is_mapped(i_paddr);
  assign o_out_drive = st_ff.out_drive;
  assign o_supply_err = st_ff.sup_err;
  assign o_load_short_err = st_ff.ld_err;
  assign o_load_open_err = st_ff.open_err;
  assign o_count_err = cnt_err;
  assign o_save_stb = st_ff.save_stb;
  assign o_irq = |(st_ff.stat & st_ff.mask);

  // ==========================================
  // Checks
  default clocking dioc_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_sup;
    st_ff.ctrl[`DIOC_SUP_EN_BIT] && i_supply_short |=> o_supply_err ##1 o_irq || !st_ff.mask[0];
  endproperty
  a_sup: assert property (p_sup) else $error("supply short not reported"); // R01
  property p_sup_off;
    !st_ff.ctrl[`DIOC_SUP_EN_BIT] |=> !o_supply_err;
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("supply error while disabled"); // R01
  property p_blank;
    blank && !o_load_short_err |=> !o_load_short_err;
  endproperty
  a_blank: assert property (p_blank) else $error("short raised during inrush"); // R02
  property p_lshort;
    st_ff.ctrl[`DIOC_LSHORT_EN_BIT] && i_over_current && !blank |=> o_load_short_err;
  endproperty
  a_lshort: assert property (p_lshort) else $error("load short not reported"); // R05
  property p_lshort_off;
    !st_ff.ctrl[`DIOC_LSHORT_EN_BIT] |=> !o_load_short_err;
  endproperty
  a_lshort_off: assert property (p_lshort_off) else $error("short error when off"); // R05
  property p_auto;
    o_load_short_err && !st_ff.ctrl[`DIOC_RECOV_BIT] && !i_over_current |=> !o_load_short_err;
  endproperty
  a_auto: assert property (p_auto) else $error("auto restart did not clear"); // R06
  property p_manual;
    o_load_short_err && st_ff.ctrl[`DIOC_RECOV_BIT] && st_ff.ctrl[`DIOC_LSHORT_EN_BIT] &&
      !wr |=> o_load_short_err;
  endproperty
  a_manual: assert property (p_manual) else $error("latched short cleared"); // R07
  property p_open;
    st_ff.ctrl[`DIOC_OPEN_EN_BIT] && i_load_open[0] |=> o_load_open_err[0];
  endproperty
  a_open: assert property (p_open) else $error("open load not reported"); // R08
  property p_open_off;
    !st_ff.ctrl[`DIOC_OPEN_EN_BIT] |=> o_load_open_err == '0;
  endproperty
  a_open_off: assert property (p_open_off) else $error("open error when off"); // R08
  property p_force;
    i_comm_fault && st_ff.ctrl[`DIOC_PRIO_BIT] && st_ff.fmode[1:0] == 2'h2 |=> o_out_drive[0];
  endproperty
  a_force: assert property (p_force) else $error("fault output not forced"); // R09
  property p_prio;
    i_comm_fault && !st_ff.ctrl[`DIOC_PRIO_BIT] |=> o_out_drive == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("fault setting used without priority"); // R10
  property p_hold;
    i_comm_fault && st_ff.ctrl[`DIOC_PRIO_BIT] && st_ff.fmode[3:2] == 2'h1 |=>
      $stable(o_out_drive[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("held output moved"); // R09
  property p_clear;
    i_comm_fault && st_ff.ctrl[`DIOC_PRIO_BIT] && st_ff.fmode[5:4] == 2'h0 |=>
      !o_out_drive[2];
  endproperty
  a_clear: assert property (p_clear) else $error("cleared output still on"); // R09
  property p_limit;
    wr && i_paddr == `DIOC_LIMIT_OFF && i_pwdata[15:0] == 16'h0000 |=> $stable(st_ff.limit);
  endproperty
  a_limit: assert property (p_limit) else $error("zero limit accepted"); // R12
  property p_limit_rng;
    st_ff.limit >= `DIOC_LIMIT_MIN && st_ff.limit <= `DIOC_LIMIT_MAX;
  endproperty
  a_limit_rng: assert property (p_limit_rng) else $error("limit out of range"); // R12
  property p_cnt_off;
    !st_ff.ctrl[`DIOC_CNT_EN_BIT] |=> o_count_err == '0;
  endproperty
  a_cnt_off: assert property (p_cnt_off) else $error("count error when off"); // R11
  property p_save;
    o_save_stb |-> $past(st_ff.hour) == 32'(HOUR_TICKS - 1) && st_ff.hour == '0;
  endproperty
  a_save: assert property (p_save) else $error("save strobe off schedule"); // R13
  property p_rst;
    disable iff (1'b0) i_rst |=> st_ff.ctrl == `DIOC_CTRL_RST && st_ff.limit == `DIOC_LIMIT_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("defaults not restored"); // R16

  c_force: cover property (i_comm_fault && st_ff.ctrl[`DIOC_PRIO_BIT] ##1 o_out_drive[0]);
  c_save: cover property (o_save_stb);
  c_latch: cover property (o_load_short_err && st_ff.ctrl[`DIOC_RECOV_BIT] && !i_over_current);
  c_cnt_err: cover property (o_count_err[0]);
endmodule // dioc_top

// >>> rtl/dioc_regs.svh
`ifndef DIOC_REGS_SVH
`define DIOC_REGS_SVH
// ==========================================
// Register offsets
`define DIOC_CTRL_OFF 8'h00
`define DIOC_FMODE_OFF 8'h04
`define DIOC_LIMIT_OFF 8'h08
`define DIOC_STAT_OFF 8'h0C
`define DIOC_MASK_OFF 8'h10
`define DIOC_INLVL_OFF 8'h14
`define DIOC_OPEN_OFF 8'h18
`define DIOC_CNTERR_OFF 8'h1C
`define DIOC_LIVE_OFF 8'h20
`define DIOC_CNT_BASE 8'h40
// ==========================================
// Control fields
`define DIOC_SUP_EN_BIT 0
`define DIOC_INRUSH_EN_BIT 1
`define DIOC_FILT_LSB 2
`define DIOC_EXT_LSB 4
`define DIOC_LSHORT_EN_BIT 6
`define DIOC_RECOV_BIT 7
`define DIOC_OPEN_EN_BIT 8
`define DIOC_CNT_EN_BIT 9
`define DIOC_PRIO_BIT 10
// Status and mask bits
`define DIOC_ST_SUP 0
`define DIOC_ST_LSHORT 1
`define DIOC_ST_OPEN 2
`define DIOC_ST_CNT 3
// ==========================================
// Reset values, limit range and limit scale
`define DIOC_CTRL_RST 11'h055
`define DIOC_LIMIT_RST 16'hFDE8
`define DIOC_LIMIT_MIN 16'h0001
`define DIOC_LIMIT_MAX 16'hFDE8
`define DIOC_LIMIT_SCALE 27'h00003E8
// ==========================================
// Timing
`define DIOC_CLK_NS 10
`define DIOC_TICK_US 100
`define DIOC_TICK_CYC ((`DIOC_TICK_US * 1000) / `DIOC_CLK_NS)
`define DIOC_US2TICK(us) ((us) / `DIOC_TICK_US)
`define DIOC_FILT0_US 100
`define DIOC_FILT1_US 1000
`define DIOC_FILT2_US 10000
`define DIOC_FILT3_US 20000
`define DIOC_EXT0_US 1000
`define DIOC_EXT1_US 15000
`define DIOC_EXT2_US 100000
`define DIOC_EXT3_US 200000
`define DIOC_INRUSH_MS 100
`define DIOC_INRUSH_TICKS `DIOC_US2TICK(`DIOC_INRUSH_MS * 1000)
`define DIOC_HOUR_S 3600
`define DIOC_HOUR_TICKS (`DIOC_HOUR_S * (1000000 / `DIOC_TICK_US))
`endif

// >>> rtl/dioc_pkg.sv
package dioc_pkg;
  typedef logic [11:0] dioc_tick_t;
  typedef logic [26:0] dioc_cnt_t;
  typedef enum logic [1:0] {DIOC_FM_CLEAR, DIOC_FM_HOLD, DIOC_FM_HIGH} dioc_fault_mode_t;
endpackage : dioc_pkg

// >>> rtl/dioc_cfg_if.sv
interface dioc_cfg_if;
  logic tick;
  dioc_pkg::dioc_tick_t filt_len;
  dioc_pkg::dioc_tick_t ext_len;
  logic cnt_en;
  dioc_pkg::dioc_cnt_t thresh;
  modport src (output tick, filt_len, ext_len, cnt_en, thresh);
  modport snk (input tick, filt_len, ext_len, cnt_en, thresh);
endinterface // dioc_cfg_if

// >>> rtl/dioc_in_cond.sv
module dioc_in_cond (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  dioc_cfg_if.snk cfg,
  input wire logic i_raw,
  output logic o_level,
  output logic o_on_evt
);
  typedef struct packed {
    logic filt;
    dioc_pkg::dioc_tick_t stab;
    dioc_pkg::dioc_tick_t ext;
    logic level;
    logic on_evt;
  } dioc_in_st_t;
  dioc_in_st_t st_ff;
  dioc_in_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.on_evt = 1'b0;
    if (i_raw == st_ff.filt) begin
      nxt_st.stab = '0;
    end else if (cfg.tick) begin
      if (st_ff.stab + 12'h001 >= cfg.filt_len) begin // R03 R15
        nxt_st.filt = i_raw;
        nxt_st.stab = '0;
        nxt_st.on_evt = i_raw;
      end else begin
        nxt_st.stab = st_ff.stab + 12'h001;
      end
    end
    if (nxt_st.on_evt) begin
      nxt_st.ext = cfg.ext_len; // R04 R15
    end else if (cfg.tick && st_ff.ext != '0) begin
      nxt_st.ext = st_ff.ext - 12'h001;
    end
    nxt_st.level = nxt_st.filt | (nxt_st.ext != '0);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.level;
  assign o_on_evt = st_ff.on_evt;

  // ==========================================
  // Checks
  property p_flt_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_raw != st_ff.filt) && !cfg.tick |=> $stable(st_ff.filt);
  endproperty
  a_flt_hold: assert property (p_flt_hold) else $error("filter moved without tick"); // R03
  property p_ext_restart;
    @(posedge i_ref_clk) disable iff (i_rst)
      st_ff.on_evt |-> (st_ff.ext == $past(cfg.ext_len)) && o_level;
  endproperty
  a_ext_restart: assert property (p_ext_restart) else $error("stretch not reloaded"); // R15
endmodule // dioc_in_cond

// >>> rtl/dioc_on_counter.sv
module dioc_on_counter (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  dioc_cfg_if.snk cfg,
  input wire logic i_on_evt,
  input wire logic i_restore_stb,
  input wire dioc_pkg::dioc_cnt_t i_restore_val,
  output dioc_pkg::dioc_cnt_t o_count,
  output logic o_limit_err
);
  typedef struct packed {
    dioc_pkg::dioc_cnt_t cnt;
    logic err;
  } dioc_cnt_st_t;
  dioc_cnt_st_t st_ff;
  dioc_cnt_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_restore_stb) begin
      nxt_st.cnt = i_restore_val; // R14
    end else if (i_on_evt && st_ff.cnt != '1) begin
      nxt_st.cnt = st_ff.cnt + 27'h0000001; // R11
    end
    nxt_st.err = cfg.cnt_en && (st_ff.cnt > cfg.thresh); // R11
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count = st_ff.cnt;
  assign o_limit_err = st_ff.err;

  // ==========================================
  // Checks
  property p_cnt_inc;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_on_evt && !i_restore_stb && st_ff.cnt != '1 |=> st_ff.cnt == $past(st_ff.cnt) + 1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count did not advance"); // R11
  property p_restore;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_restore_stb |=> st_ff.cnt == $past(i_restore_val);
  endproperty
  a_restore: assert property (p_restore) else $error("count not restored"); // R14
endmodule // dioc_on_counter

// >>> dv/dioc_field_model.sv
// ==========================================
// Field sensors and output loads
module dioc_field_model #(
  parameter int NCH = 8
) (
  input wire logic i_ref_clk,
  input wire logic [NCH-1:0] i_sense_on,
  input wire logic [NCH-1:0] i_shorted,
  input wire logic [NCH-1:0] i_broken,
  input wire logic i_sup_fault,
  input wire logic [NCH-1:0] i_out_drive,
  output logic [NCH-1:0] o_in_raw,
  output logic o_supply_short,
  output logic o_over_current,
  output logic [NCH-1:0] o_load_open
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_in_raw = '0;
    o_supply_short = 1'h0;
    o_over_current = 1'h0;
    o_load_open = '0;
  end
  // Shorted load draws excess current only while driven
  always @(posedge i_ref_clk) begin
    o_in_raw <= i_sense_on;
    o_supply_short <= i_sup_fault;
    o_over_current <= |(i_out_drive & i_shorted);
    o_load_open <= i_broken;
  end
endmodule // dioc_field_model

// >>> dv/dioc_top_tb.sv
`include "dioc_regs.svh"
module dioc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 8;
  localparam int TICK = 10;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, err;
  logic [31:0] rd;
  logic [NCH-1:0] sense_on = '0, shorted = '0, broken = '0, out_cmd = '0;
  logic sup_fault = 1'h0, comm_fault = 1'h0, restore_stb = 1'h0;
  logic [NCH*27-1:0] restore_cnt = '0, save_cnt;
  logic [NCH-1:0] in_raw, load_open, in_level, out_drive, open_err, count_err;
  logic supply_short, over_current, supply_err, short_err, save_stb, irq;
  int bad_count = 0, num_checks = 0, cycles = 0;
  int lens[4] = '{1, 10, 100, 200};
  always #5 clk = ~clk;
  dioc_field_model #(.NCH(NCH)) fm (.i_ref_clk(clk), .i_sense_on(sense_on),
    .i_shorted(shorted), .i_broken(broken), .i_sup_fault(sup_fault),
    .i_out_drive(out_drive), .o_in_raw(in_raw), .o_supply_short(supply_short),
    .o_over_current(over_current), .o_load_open(load_open));
  dioc_top #(.NCH(NCH), .TICK_CYC(TICK), .INRUSH_TICKS(20), .HOUR_TICKS(50)) uut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_in_raw(in_raw), .i_out_cmd(out_cmd),
    .i_comm_fault(comm_fault), .i_supply_short(supply_short),
    .i_over_current(over_current), .i_load_open(load_open),
    .i_restore_stb(restore_stb), .i_restore_cnt(restore_cnt), .o_in_level(in_level),
    .o_out_drive(out_drive), .o_supply_err(supply_err), .o_load_short_err(short_err),
    .o_load_open_err(open_err), .o_count_err(count_err), .o_save_stb(save_stb),
    .o_save_cnt(save_cnt), .o_irq(irq));
  // ==========================================
  // Helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Land between edges so registered outputs are settled
  task automatic mid(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string msg);
    num_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s act=%h exp=%h", $time, msg, act, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'h0, a, 32'h0);
    chk(rd, exp, msg);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    cyc(20);
    rst <= 1'h0;
    cyc(1);
    rdc(`DIOC_CTRL_OFF, 32'h55, "ctrl reset");
    rdc(`DIOC_LIMIT_OFF, 32'hFDE8, "limit reset");
    rdc(`DIOC_FMODE_OFF, 32'h0, "fmode reset");
    apb(1'h0, 8'h3C, 32'h0);
    chk(err, 32'h1, "unmapped slverr");
    wr(`DIOC_MASK_OFF, 32'hF);
    sup_fault <= 1'h1;
    mid(4);
    chk(supply_err, 32'h1, "supply err");
    chk(irq, 32'h1, "irq");
    cyc(1);
    sup_fault <= 1'h0;
    cyc(3);
    wr(`DIOC_STAT_OFF, 32'h1);
    rdc(`DIOC_STAT_OFF, 32'h0, "stat w1c");
    wr(`DIOC_CTRL_OFF, 32'h54);
    sup_fault <= 1'h1;
    mid(4);
    chk(supply_err, 32'h0, "supply off");
    chk(irq, 32'h0, "irq off");
    cyc(1);
    sup_fault <= 1'h0;
    wr(`DIOC_CTRL_OFF, 32'h55);
    out_cmd <= 8'h01;
    shorted <= 8'h01;
    mid(5);
    chk(short_err, 32'h1, "short err");
    cyc(1);
    shorted <= 8'h00;
    mid(5);
    chk(short_err, 32'h0, "auto clear");
    cyc(1);
    wr(`DIOC_CTRL_OFF, 32'hD5);
    shorted <= 8'h01;
    mid(5);
    cyc(1);
    shorted <= 8'h00;
    mid(5);
    chk(short_err, 32'h1, "manual latch");
    cyc(1);
    wr(`DIOC_CTRL_OFF, 32'h15);
    shorted <= 8'h01;
    mid(5);
    chk(short_err, 32'h0, "short off");
    cyc(1);
    out_cmd <= 8'h00;
    wr(`DIOC_CTRL_OFF, 32'h57);
    out_cmd <= 8'h01;
    mid(50);
    chk(short_err, 32'h0, "inrush blank");
    mid(210);
    chk(short_err, 32'h1, "after inrush");
    cyc(1);
    out_cmd <= 8'h00;
    shorted <= 8'h00;
    broken <= 8'h09;
    wr(`DIOC_CTRL_OFF, 32'h55);
    mid(4);
    chk(open_err, 32'h0, "open off");
    cyc(1);
    wr(`DIOC_CTRL_OFF, 32'h155);
    mid(4);
    chk(open_err, 32'h9, "open err");
    cyc(1);
    broken <= 8'h00;
    wr(`DIOC_CTRL_OFF, 32'h55);
    wr(`DIOC_FMODE_OFF, 32'hC6);
    out_cmd <= 8'h06;
    comm_fault <= 1'h1;
    mid(3);
    chk(out_drive, 32'h0, "fault no prio");
    cyc(1);
    comm_fault <= 1'h0;
    mid(3);
    chk(out_drive, 32'h6, "no fault");
    cyc(1);
    wr(`DIOC_CTRL_OFF, 32'h455);
    comm_fault <= 1'h1;
    out_cmd <= 8'h00;
    mid(3);
    chk(out_drive, 32'h3, "fault modes");
    cyc(1);
    comm_fault <= 1'h0;
    for (int f = 0; f < 4; f++) begin
      int c;
      c = lens[f] * TICK;
      wr(`DIOC_CTRL_OFF, 32'h41 | (f << 2));
      sense_on <= 8'h02;
      if (f > 0) begin
        mid(c - 20);
        chk(in_level[1], 32'h0, "filter early");
      end
      mid((f > 0) ? 40 : c + 20);
      chk(in_level[1], 32'h1, "filter pass");
      cyc(1);
      sense_on <= 8'h00;
      mid(c + 140);
      chk(in_level[1], 32'h0, "filter fall");
      cyc(1);
    end
    wr(`DIOC_CTRL_OFF, 32'h41);
    sense_on <= 8'h04;
    mid(40);
    cyc(1);
    sense_on <= 8'h00;
    mid(40);
    chk(in_level[2], 32'h1, "stretch hold");
    mid(90);
    chk(in_level[2], 32'h0, "stretch end");
    cyc(1);
    wr(`DIOC_LIMIT_OFF, 32'h1);
    wr(`DIOC_LIMIT_OFF, 32'h0);
    wr(`DIOC_LIMIT_OFF, 32'hFDE9);
    rdc(`DIOC_LIMIT_OFF, 32'h1, "limit range");
    restore_cnt <= (NCH * 27)'(27'h00003E8);
    restore_stb <= 1'h1;
    cyc(1);
    restore_stb <= 1'h0;
    wr(`DIOC_CTRL_OFF, 32'h255);
    rdc(`DIOC_CNT_BASE, 32'h3E8, "restored");
    mid(1);
    chk(count_err[0], 32'h0, "at limit");
    cyc(1);
    out_cmd <= 8'h01;
    mid(4);
    chk(count_err[0], 32'h1, "over limit");
    cyc(1);
    rdc(`DIOC_CNT_BASE, 32'h3E9, "count");
    apb(1'h0, `DIOC_STAT_OFF, 32'h0);
    chk(rd & 32'h8, 32'h8, "stat cnt");
    for (int i = 0; i < 600 && save_stb !== 1'h1; i++) @(negedge clk);
    chk(save_stb, 32'h1, "save pulse");
    chk(save_cnt[26:0], 32'h3E9, "save count");
    cyc(1);
    report_and_stop;
  end
endmodule // dioc_top_tb
